// ===== logic/rcd_router_ctrl.sv
/*
 * Router control-code logic: packet length truncation, time-code
 * distribution and distributed interrupt distribution.
 * Assumes synchronous inputs, one code per port per cycle, and that
 * port 0 input characters are the configuration port's replies.
 */
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "rcd_map.svh"
module rcd_router_ctrl
   import rcd_pkg::*;
(
   // Clock and reset
   input  wire logic                 I_CLK,
   input  wire logic                 I_RST,
   // Straps for distribution reset config
   input  wire logic [1:0]           I_GPIO_IRQ,
   // Register bus
   input  wire rcd_bus_s             I_BUS,
   output logic [31:0]               O_RDATA,
   // Data characters per input port
   input  wire rcd_char_s [`RCD_NPORT-1:0] I_CHAR,
   output logic [`RCD_NPORT-1:0]     O_SPILL,
   output logic [`RCD_NPORT-1:0]     O_EEP,
   // Control codes, ports then aux
   input  wire rcd_code_s [`RCD_NSRC-1:0]  I_CC,
   output rcd_code_s [`RCD_NSRC-1:0]       O_CC
);
   // ***********************
   // Registers
   // ***********************
   logic [7:0]             cfg;        // Router config
   logic                   tc_en;      // Global time-code enable
   logic [7:0]             tc;         // Flags and time
   logic [`RCD_NIRQ-1:0]   status;     // Both status words
   logic [`RCD_TW-1:0]     exp_rl;     // Expiry reload
   logic [`RCD_TW-1:0]     chg_rl;     // Change reload
   logic [2:0]             pc [`RCD_NPORT];   // Port control
   logic [3:0]             px [`RCD_NPORT];   // Port control extra
   logic [15:0]            mpl [`RCD_NPORT];  // Max length
   logic                   strap_done; // Straps taken

   wire logic [1:0] bsel = I_BUS.addr[5:4];
   wire logic [1:0] bport = I_BUS.addr[1:0];

   // Config writes; straps land on the first edge after release
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         cfg        <= 8'h00;
         strap_done <= 1'b0;
      end else if (!strap_done) begin
         strap_done           <= 1'b1;
         cfg[`RCD_CFG_IE]     <= I_GPIO_IRQ[1];
         cfg[`RCD_CFG_EE]     <= I_GPIO_IRQ[0];
      end else if (I_BUS.wr && I_BUS.addr == `RCD_OFF_CFG) begin
         cfg <= I_BUS.wdata[7:0];
      end
   end

   // Reload values and global time enable
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         exp_rl <= '0;
         chg_rl <= '0;
         tc_en  <= 1'b0;
      end else if (I_BUS.wr) begin
         if (I_BUS.addr == `RCD_OFF_EXP) begin
            exp_rl <= I_BUS.wdata[`RCD_TW-1:0];
         end
         if (I_BUS.addr == `RCD_OFF_CHG) begin
            chg_rl <= I_BUS.wdata[`RCD_TW-1:0];
         end
         if (I_BUS.addr == `RCD_OFF_TC) begin
            tc_en <= I_BUS.wdata[`RCD_TC_EN];
         end
      end
   end

   // Per-port tables, indexed by the low address bits
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         for (int p = 0; p < `RCD_NPORT; p++) begin
            pc[p]  <= 3'h0;
            px[p]  <= 4'h0;
            mpl[p] <= `RCD_MPL_RST;
         end
      end else if (I_BUS.wr && I_BUS.addr[3:2] == 2'h0) begin
         case (bsel)
            2'(`RCD_OFF_PC):  pc[bport]  <= I_BUS.wdata[2:0];
            2'(`RCD_OFF_PCX): px[bport]  <= I_BUS.wdata[3:0];
            2'(`RCD_OFF_MPL): mpl[bport] <= I_BUS.wdata[15:0];
            default: ;
         endcase
      end
   end

   // Read data stands one cycle after the strobe; unmapped reads zero
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_RDATA <= 32'h0;
      end else if (!I_BUS.rd) begin
         O_RDATA <= 32'h0;
      end else if (I_BUS.addr[5:4] == 2'h0) begin
         case (I_BUS.addr)
            `RCD_OFF_CFG: O_RDATA <= {24'h0, cfg};
            `RCD_OFF_TC:  O_RDATA <= {23'h0, tc_en, tc};
            `RCD_OFF_ISL: O_RDATA <= status[31:0];
            `RCD_OFF_ISH: O_RDATA <= status[63:32];
            `RCD_OFF_EXP: O_RDATA <= {16'h0, exp_rl};
            `RCD_OFF_CHG: O_RDATA <= {16'h0, chg_rl};
            default:      O_RDATA <= 32'h0;
         endcase
      end else if (I_BUS.addr[3:2] == 2'h0) begin
         case (bsel)
            2'(`RCD_OFF_PC):  O_RDATA <= {29'h0, pc[bport]};
            2'(`RCD_OFF_PCX): O_RDATA <= {28'h0, px[bport]};
            2'(`RCD_OFF_MPL): O_RDATA <= {16'h0, mpl[bport]};
            default:          O_RDATA <= 32'h0;
         endcase
      end else begin
         O_RDATA <= 32'h0;
      end
   end

   // ***********************
   // Packet length truncation
   // ***********************
   logic [15:0] len [`RCD_NPORT];   // Characters seen
   rcd_len_e    lst [`RCD_NPORT];   // Pass or spill

   // Port 0 input carries the config port replies, so the same
   // monitor limits reply length there
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         for (int p = 0; p < `RCD_NPORT; p++) begin
            len[p] <= 16'h0;
            lst[p] <= LEN_PASS;
         end
         O_EEP <= '0;
      end else begin
         for (int p = 0; p < `RCD_NPORT; p++) begin
            O_EEP[p] <= 1'b0;
            if (I_CHAR[p].valid && I_CHAR[p].eop) begin
               len[p] <= 16'h0;
               lst[p] <= LEN_PASS;
            end else if (I_CHAR[p].valid && lst[p] == LEN_PASS) begin
               // Saturate so a huge packet cannot wrap the count
               if (len[p] != 16'hffff) begin
                  len[p] <= len[p] + 16'h1;
               end
               if (len[p] >= mpl[p] && pc[p][`RCD_PC_PL]) begin
                  lst[p]   <= LEN_SPILL;
                  O_EEP[p] <= 1'b1;
               end
            end
         end
      end
   end

   always_comb begin
      for (int p = 0; p < `RCD_NPORT; p++) begin
         O_SPILL[p] = (lst[p] == LEN_SPILL);
      end
   end

   // ***********************
   // Enables per source, aux last
   // ***********************
   logic [`RCD_NSRC-1:0] s_te, s_ic, s_ir, s_ar, s_it, s_at;

   always_comb begin
      for (int p = 0; p < `RCD_NPORT; p++) begin
         s_te[p] = pc[p][`RCD_PC_TE];
         s_ic[p] = pc[p][`RCD_PC_IC];
         s_ir[p] = px[p][`RCD_PX_IR];
         s_ar[p] = px[p][`RCD_PX_AR];
         s_it[p] = px[p][`RCD_PX_IT];
         s_at[p] = px[p][`RCD_PX_AT];
      end
      s_te[`RCD_AUX] = cfg[`RCD_CFG_AT];
      s_ic[`RCD_AUX] = cfg[`RCD_CFG_AI];
      s_ir[`RCD_AUX] = cfg[`RCD_CFG_AI];
      s_ar[`RCD_AUX] = cfg[`RCD_CFG_AI];
      s_it[`RCD_AUX] = cfg[`RCD_CFG_AI];
      s_at[`RCD_AUX] = cfg[`RCD_CFG_AI];
   end

   // ***********************
   // Time-codes
   // ***********************
   logic       tc_hit;   // A time-code accepted
   logic [7:0] tc_new;   // Its value
   logic [2:0] tc_src;   // Its source

   // Lowest source wins when several arrive together
   always_comb begin
      tc_hit = 1'b0;
      tc_new = 8'h0;
      tc_src = 3'h0;
      for (int s = `RCD_NSRC - 1; s >= 0; s--) begin
         if (I_CC[s].valid && tc_en && s_te[s]
             && (I_CC[s].data[7:6] == `RCD_FL_TIME
                 || (!cfg[`RCD_CFG_TF] && !cfg[`RCD_CFG_IE]))) begin
            tc_hit = 1'b1;
            tc_new = I_CC[s].data;
            tc_src = 3'(s);
         end
      end
   end

   wire logic tc_fwd = tc_hit && (tc_new[5:0] == tc[5:0] + 6'h1);

   // Every accepted code updates the counter, forwarded or not
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         tc <= 8'h0;
      end else if (tc_hit) begin
         tc <= tc_new;
      end
   end

   // ***********************
   // Distributed interrupt intake
   // ***********************
   logic [`RCD_NIRQ-1:0] pend;      // Waiting numbers
   logic [`RCD_NIRQ-1:0] pcls;      // Waiting code is ack/extended
   logic [2:0]           psrc [`RCD_NIRQ]; // Waiting code source
   logic [`RCD_NIRQ-1:0] take, t_cls, a_set, a_clr;
   logic [2:0]           t_src [`RCD_NIRQ];
   logic [`RCD_NIRQ-1:0] chg_busy, exp_done;
   logic [5:0]           num;
   logic                 b5;
   logic                 ok;
   wire logic            ext = cfg[`RCD_CFG_EE];

   // Sources are scanned in order so a second code for a number
   // already taken this cycle is discarded like a queued one
   always_comb begin
      take = '0;
      t_cls = '0;
      a_set = '0;
      a_clr = '0;
      num = 6'h0;
      b5 = 1'b0;
      ok = 1'b0;
      for (int n = 0; n < `RCD_NIRQ; n++) begin
         t_src[n] = 3'h0;
      end
      for (int s = 0; s < `RCD_NSRC; s++) begin
         b5  = I_CC[s].data[5];
         num = {ext & b5, I_CC[s].data[4:0]};
         ok  = I_CC[s].valid && I_CC[s].data[7:6] == `RCD_FL_IRQ
            && cfg[`RCD_CFG_IE] && s_ic[s]
            && (b5 ? s_ar[s] : s_ir[s])
            && ((b5 && !ext) ? status[num] : !status[num])
            && !pend[num] && !take[num]
            && !(cfg[`RCD_CFG_IC] && chg_busy[num]);
         if (ok) begin
            take[num]  = 1'b1;
            t_cls[num] = b5;
            t_src[num] = 3'(s);
            if (b5 && !ext) begin
               a_clr[num] = 1'b1;
            end else begin
               a_set[num] = 1'b1;
            end
         end
      end
   end

   // New codes set or clear; an arriving set beats an expiry clear
   wire logic [`RCD_NIRQ-1:0] next_status =
      (status & ~a_clr & ~exp_done) | a_set;

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         status <= '0;
      end else begin
         status <= next_status;
      end
   end

   // ***********************
   // Per-number timers
   // ***********************
   genvar g;
   generate
      for (g = 0; g < `RCD_NIRQ; g++) begin : g_num
         rcd_num_timer u_exp (
            .i_clk    (I_CLK),
            .i_rst    (I_RST),
            .i_load   (a_set[g]),
            .i_stop   (a_clr[g]),
            .i_value  (exp_rl),
            .o_busy   (),
            .o_expire (exp_done[g])
         );
         rcd_num_timer u_chg (
            .i_clk    (I_CLK),
            .i_rst    (I_RST),
            .i_load   (cfg[`RCD_CFG_IC] && (next_status[g] != status[g])),
            .i_stop   (1'b0),
            .i_value  (chg_rl),
            .o_busy   (chg_busy[g]),
            .o_expire ()
         );
      end
   endgenerate

   // ***********************
   // Queue service
   // ***********************
   logic [`RCD_NIRQ-1:0] cand;     // Class chosen this cycle
   logic [5:0]           sel;      // Served number
   logic                 sel_hit;  // Something to serve
   logic [5:0]           rr_last;  // Last served number
   logic [5:0]           idx;

   // Class priority first, then lowest number or round robin
   always_comb begin
      cand = pend & (cfg[`RCD_CFG_IP] ? pcls : ~pcls);
      if (cand == '0) begin
         cand = pend;
      end
      sel = 6'h0;
      sel_hit = 1'b0;
      idx = 6'h0;
      for (int k = `RCD_NIRQ - 1; k >= 0; k--) begin
         idx = cfg[`RCD_CFG_IS] ? 6'(k) : 6'(rr_last + 6'h1 + 6'(k));
         if (cand[idx]) begin
            sel = idx;
            sel_hit = 1'b1;
         end
      end
   end

   // Time-code forwarding owns the outputs for its cycle
   wire logic serve = sel_hit && !tc_fwd;

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         pend    <= '0;
         pcls    <= '0;
         rr_last <= 6'h3f;
         for (int n = 0; n < `RCD_NIRQ; n++) begin
            psrc[n] <= 3'h0;
         end
      end else begin
         for (int n = 0; n < `RCD_NIRQ; n++) begin
            if (take[n]) begin
               pend[n] <= 1'b1;
               pcls[n] <= t_cls[n];
               psrc[n] <= t_src[n];
            end else if (serve && sel == 6'(n)) begin
               pend[n] <= 1'b0;
            end
         end
         if (serve) begin
            rr_last <= sel;
         end
      end
   end

   // ***********************
   // Code outputs
   // ***********************
   // Source is skipped, which also keeps aux codes off the aux side
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_CC <= '0;
      end else begin
         for (int d = 0; d < `RCD_NSRC; d++) begin
            O_CC[d].valid <= 1'b0;
            O_CC[d].data  <= 8'h0;
            if (tc_fwd) begin
               if (3'(d) != tc_src && s_te[d]) begin
                  O_CC[d].valid <= 1'b1;
                  O_CC[d].data  <= tc_new;
               end
            end else if (serve && 3'(d) != psrc[sel] && s_ic[d]
                         && (pcls[sel] ? s_at[d] : s_it[d])) begin
               O_CC[d].valid <= 1'b1;
               O_CC[d].data  <= {`RCD_FL_IRQ, pcls[sel], sel[4:0]};
            end
         end
      end
   end
endmodule : rcd_router_ctrl
`default_nettype wire

// ===== inc/rcd_map.svh
/*
 * Address map, field positions, reset values and sizes of the
 * router control-code block. Assumes a 6-bit word index bus.
 */
`ifndef RCD_MAP_SVH
`define RCD_MAP_SVH
// ***********************
// Sizes
// ***********************
`define RCD_NPORT    4
`define RCD_NSRC     5
`define RCD_AUX      4
`define RCD_NIRQ     64
`define RCD_TW       16
// ***********************
// Register word index
// ***********************
`define RCD_OFF_CFG  6'h00
`define RCD_OFF_TC   6'h01
`define RCD_OFF_ISL  6'h02
`define RCD_OFF_ISH  6'h03
`define RCD_OFF_EXP  6'h04
`define RCD_OFF_CHG  6'h05
`define RCD_OFF_PC   4'h1
`define RCD_OFF_PCX  4'h2
`define RCD_OFF_MPL  4'h3
// ***********************
// Fields
// ***********************
`define RCD_CFG_TF   0
`define RCD_CFG_IE   1
`define RCD_CFG_EE   2
`define RCD_CFG_IC   3
`define RCD_CFG_IS   4
`define RCD_CFG_IP   5
`define RCD_CFG_AT   6
`define RCD_CFG_AI   7
`define RCD_TC_EN    8
`define RCD_PC_PL    0
`define RCD_PC_TE    1
`define RCD_PC_IC    2
`define RCD_PX_IR    0
`define RCD_PX_AR    1
`define RCD_PX_IT    2
`define RCD_PX_AT    3
`define RCD_FL_TIME  2'b00
`define RCD_FL_IRQ   2'b10
`define RCD_MPL_RST  16'hffff
`endif

// ===== inc/rcd_pkg.sv
/*
 * Types shared by the router control-code block.
 * Assumes rcd_map.svh sizes.
 */
`include "rcd_map.svh"
package rcd_pkg;
   // Control code on one port
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } rcd_code_s;
   // Data character marker on one input port
   typedef struct packed {
      logic valid;
      logic eop;
   } rcd_char_s;
   // Register bus request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [5:0]  addr;
      logic [31:0] wdata;
   } rcd_bus_s;
   // Length monitor state
   typedef enum logic {
      LEN_PASS  = 1'b0,
      LEN_SPILL = 1'b1
   } rcd_len_e;
endpackage : rcd_pkg

// ===== logic/rcd_num_timer.sv
/*
 * Down counter for one interrupt number.
 * Assumes load and stop are one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rcd_map.svh"
module rcd_num_timer
   import rcd_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // Control
   input  wire logic              i_load,
   input  wire logic              i_stop,
   input  wire logic [`RCD_TW-1:0] i_value,
   // Status
   output logic                   o_busy,
   output logic                   o_expire
);
   logic [`RCD_TW-1:0] cnt;   // Remaining ticks

   // Load wins over stop; zero means idle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= '0;
      end else if (i_load) begin
         cnt <= i_value;
      end else if (i_stop) begin
         cnt <= '0;
      end else if (cnt != '0) begin
         cnt <= cnt - `RCD_TW'(1);
      end
   end

   // Pulse on the tick that reaches zero
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_expire <= 1'b0;
      end else begin
         o_expire <= (cnt == `RCD_TW'(1)) && !i_load && !i_stop;
      end
   end

   assign o_busy = (cnt != '0);
endmodule : rcd_num_timer
`default_nettype wire

// ===== verif/rcd_node.sv
/*
 * Remote link node model: sends one control code per request.
 * Assumes requests are spaced wider than its send delay.
 */
`timescale 1ns/1ps
`default_nettype none
module rcd_node
   import rcd_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Request from the bench
   input  wire logic       i_req,
   input  wire logic [7:0] i_code,
   input  wire logic       i_slow,
   // Code towards the router
   output rcd_code_s       o_cc
);
   logic [1:0] wait_cnt; // Cycles left before the code goes out
   logic       armed;    // A code is held for sending
   logic [7:0] held;     // The held code
   logic       fire;     // Send in this cycle
   assign fire = armed && (wait_cnt == 2'h0);
   // Idle data toggles so a stale code never passes for a fresh one
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         armed <= 1'b0;
         held <= 8'h00;
         wait_cnt <= 2'h0;
         o_cc <= '0;
      end else begin
         o_cc.valid <= fire;
         o_cc.data <= fire ? held : ~o_cc.data;
         if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
         end else if (armed) begin
            armed <= 1'b0;
         end
         // A slow node waits three cycles
         if (i_req) begin
            armed <= 1'b1;
            held <= i_code;
            wait_cnt <= i_slow ? 2'h3 : 2'h0;
         end
      end
   end
endmodule : rcd_node
`default_nettype wire

// ===== verif/rcd_chk.sv
/*
 * Port-level checker of the control-code router.
 * Assumes one clock domain and the top module's port widths.
 */
`timescale 1ns/1ps
`default_nettype none
module rcd_chk
   import rcd_pkg::*;
(
   input  wire logic                 I_CLK,
   input  wire logic                 I_RST,
   input  wire rcd_bus_s             I_BUS,
   input  wire logic [31:0]          O_RDATA,
   input  wire rcd_char_s [3:0]      I_CHAR,
   input  wire logic [3:0]           O_SPILL,
   input  wire logic [3:0]           O_EEP,
   input  wire rcd_code_s [4:0]      I_CC,
   input  wire rcd_code_s [4:0]      O_CC
);
   // *********************
   // Helpers
   // *********************
   wire logic any_port; // Some port delivers a code
   wire logic any_cc;   // Some source delivers a code
   assign any_port = I_CC[0].valid | I_CC[1].valid | I_CC[2].valid | I_CC[3].valid;
   assign any_cc = any_port | I_CC[4].valid;
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RST);
   // *********************
   // Properties
   // *********************
   property p_aux_no_echo;
      I_CC[4].valid && (I_CC[4].data[7:6] == 2'b00) && !any_port |=> !(O_CC[4].valid && O_CC[4].data[7:6] == 2'b00);
   endproperty
   a_aux_no_echo: assert property (p_aux_no_echo) else $error("aux time code echoed");
   property p_tc_no_echo;
      I_CC[1].valid && (I_CC[1].data[7:6] == 2'b00) && !I_CC[0].valid |=> !(O_CC[1].valid && O_CC[1].data[7:6] == 2'b00);
   endproperty
   a_tc_no_echo: assert property (p_tc_no_echo) else $error("time code echoed");
   property p_tc_cause;
      O_CC[0].valid && (O_CC[0].data[7:6] == 2'b00) |-> $past(any_cc);
   endproperty
   a_tc_cause: assert property (p_tc_cause) else $error("time code without source");
   property p_eep_start;
      (O_SPILL & ~$past(O_SPILL)) == O_EEP;
   endproperty
   a_eep_start: assert property (p_eep_start) else $error("eep and spill start apart");
   property p_eep_pulse;
      O_EEP[1] |=> !O_EEP[1] [*2];
   endproperty
   a_eep_pulse: assert property (p_eep_pulse) else $error("eep longer than one pulse");
   property p_eep_cause;
      O_EEP[1] |-> $past(I_CHAR[1].valid && !I_CHAR[1].eop);
   endproperty
   a_eep_cause: assert property (p_eep_cause) else $error("eep without character");
   property p_spill_hold;
      O_SPILL[1] && !(I_CHAR[1].valid && I_CHAR[1].eop) |=> O_SPILL[1];
   endproperty
   a_spill_hold: assert property (p_spill_hold) else $error("spill ended early");
   property p_spill_end;
      O_SPILL[1] && I_CHAR[1].valid && I_CHAR[1].eop |=> !O_SPILL[1];
   endproperty
   a_spill_end: assert property (p_spill_end) else $error("spill kept past end");
   property p_rd_tc;
      I_BUS.rd && (I_BUS.addr == 6'h01) |=> O_RDATA[31:9] == 23'h0;
   endproperty
   a_rd_tc: assert property (p_rd_tc) else $error("time counter upper bits set");
endmodule : rcd_chk
bind rcd_router_ctrl rcd_chk rcd_chk_i (.I_CLK(I_CLK), .I_RST(I_RST), .I_BUS(I_BUS), .O_RDATA(O_RDATA),
   .I_CHAR(I_CHAR), .O_SPILL(O_SPILL), .O_EEP(O_EEP), .I_CC(I_CC), .O_CC(O_CC));
`default_nettype wire

// ===== verif/rcd_router_ctrl_tb.sv
/*
 * Self-checking bench of the control-code router.
 * Assumes strap pins tied for distribution on, acknowledge mode.
 */
`timescale 1ns/1ps
`default_nettype none
module rcd_router_ctrl_tb;
   import rcd_pkg::*;
   logic             I_CLK = 1'b0;  // 50 MHz clock
   logic             I_RST = 1'b1;  // Reset, high
   rcd_bus_s         bus = '0;      // Register requests
   logic [31:0]      rdata;         // Read data
   rcd_char_s [3:0]  chr = '0;      // Data characters
   logic [3:0]       spill;         // Spill levels
   logic [3:0]       eep;           // Error end markers
   wire rcd_code_s [4:0] cc_in;     // Codes from the nodes
   rcd_code_s [4:0]  cc_out;        // Codes to the nodes
   logic [4:0]       req = '0;      // Node requests
   logic [4:0][7:0]  cd = '0;       // Node codes
   logic             slow = 1'b0;   // Node pace
   logic [11:0]      expq [$];      // Expected {eep, dest, code}
   int               n_errors = 0;
   int               cmp_count = 0;
   int               cyc = 0;
   always #10 I_CLK = ~I_CLK;
   // *********************
   // Design and nodes
   // *********************
   rcd_router_ctrl rcd_router_ctrl_i (.I_CLK(I_CLK), .I_RST(I_RST), .I_GPIO_IRQ(2'b10), .I_BUS(bus),
      .O_RDATA(rdata), .I_CHAR(chr), .O_SPILL(spill), .O_EEP(eep), .I_CC(cc_in), .O_CC(cc_out));
   for (genvar s = 0; s < 5; s++) begin : g_node
      rcd_node rcd_node_i (.i_clk(I_CLK), .i_rst(I_RST), .i_req(req[s]), .i_code(cd[s]),
         .i_slow(slow), .o_cc(cc_in[s]));
   end
   // *********************
   // Tasks
   // *********************
   task automatic finish_test();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic pop(input logic [11:0] seen);
      logic [11:0] e;
      e = (expq.size() > 0) ? expq.pop_front() : 12'hfff;
      check("output", 32'(seen), 32'(e));
   endtask : pop
   // Writes leave a gap so the strobe is never set twice at one edge
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge I_CLK);
      bus <= '0;
      @(posedge I_CLK);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [31:0] exp);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge I_CLK);
      bus <= '0;
      @(negedge I_CLK);
      check("rdata", rdata, exp);
      @(posedge I_CLK);
   endtask : rd
   task automatic send(input int s, input logic [7:0] c);
      cd[s] <= c;
      req <= 5'(1) << s;
      slow <= 1'($urandom_range(1, 0));
      @(posedge I_CLK);
      req <= '0;
      repeat (8) @(posedge I_CLK);
   endtask : send
   task automatic expect_cc(input int src, input logic [7:0] c, input logic [4:0] dm);
      for (int d = 0; d < 5; d++) begin
         if (dm[d] && d != src) expq.push_back({1'b0, 3'(d), c});
      end
   endtask : expect_cc
   // *********************
   // Output watcher
   // *********************
   always @(negedge I_CLK) begin
      if (I_RST === 1'b0) begin
         for (int d = 0; d < 5; d++) begin
            if (cc_out[d].valid === 1'b1) pop({1'b0, 3'(d), cc_out[d].data});
         end
         for (int p = 0; p < 4; p++) begin
            if (eep[p] === 1'b1) pop({1'b1, 3'(p), 8'h00});
         end
      end
   end
   // Hang guard, far above the few hundred cycles needed
   always @(posedge I_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         finish_test();
      end
   end
   // *********************
   // Main sequence
   // *********************
   initial begin
      int m;
      logic [5:0] t;
      logic [5:0] old;
      logic [31:0] st;
      int a;
      void'($urandom(18));
      repeat (10) @(posedge I_CLK);
      I_RST <= 1'b0;
      repeat (2) @(posedge I_CLK);
      rd(6'h00, 32'h2);
      rd(6'h31, 32'hffff);
      rd(6'h0f, 32'h0);
      wr(6'h00, 32'hc2);
      wr(6'h01, 32'h100);
      wr(6'h04, 32'h0);
      wr(6'h05, 32'h0);
      for (int p = 0; p < 4; p++) begin
         wr(6'h10 + 6'(p), (p == 3) ? 32'h4 : (p == 1) ? 32'h7 : 32'h6);
         wr(6'h20 + 6'(p), 32'hf);
      end
      $display("test setup done");
      // Over-long packet, then one at the limit
      m = $urandom_range(4, 1);
      wr(6'h31, 32'(m));
      for (int k = 0; k < 2; k++) begin
         if (k == 0) expq.push_back({1'b1, 3'd1, 8'h00});
         for (int i = 0; i <= m + 2 - 2 * k; i++) begin
            chr[1] <= '{valid: 1'b1, eop: (i == m + 2 - 2 * k)};
            @(posedge I_CLK);
         end
      end
      chr[1] <= '0;
      repeat (4) @(posedge I_CLK);
      $display("test length done");
      // Time codes: in step, out of step, disabled port, flags 01
      old = 6'h0;
      t = 6'($urandom_range(63, 0));
      for (int i = 0; i < 3; i++) begin
         if (t == old + 6'h1) expect_cc(1, {2'b00, t}, 5'b10101);
         send(1, {2'b00, t});
         rd(6'h01, {23'h0, 1'b1, 2'b00, t});
         old = t;
         t = t + 6'(i + 1);
      end
      send(3, {2'b00, old + 6'h1});
      send(2, {2'b01, old + 6'h1});
      rd(6'h01, {23'h0, 1'b1, 2'b00, old});
      $display("test timecode done");
      // Interrupt set, repeat refused, then class priority both ways
      expect_cc(0, 8'h85, 5'h1f);
      send(0, 8'h85);
      send(1, 8'h85);
      st = 32'h20;
      rd(6'h02, st);
      for (int ip = 0; ip < 2; ip++) begin
         a = 9 + 4 * ip;
         wr(6'h00, 32'hc2 | (32'(ip) << 5));
         expect_cc(0, 8'h80 | 8'(a), 5'h1f);
         send(0, 8'h80 | 8'(a));
         if (ip == 0) expect_cc(2, 8'h80 | 8'(a + 2), 5'h1f);
         expect_cc(1, 8'ha0 | 8'(a), 5'h1f);
         if (ip == 1) expect_cc(2, 8'h80 | 8'(a + 2), 5'h1f);
         cd[1] <= 8'ha0 | 8'(a);
         cd[2] <= 8'h80 | 8'(a + 2);
         req <= 5'b00110;
         @(posedge I_CLK);
         req <= '0;
         repeat (10) @(posedge I_CLK);
         st = (st & ~(32'h1 << a)) | (32'h1 << (a + 2));
         rd(6'h02, st);
      end
      $display("test interrupt done");
      // Extended mode and a code from the auxiliary side
      wr(6'h00, 32'hc6);
      expect_cc(2, 8'ha3, 5'h1f);
      send(2, 8'ha3);
      rd(6'h03, 32'h8);
      expect_cc(4, 8'h81, 5'h1f);
      send(4, 8'h81);
      rd(6'h02, st | 32'h2);
      // Short expiry: a fresh interrupt with no acknowledge drops out
      wr(6'h04, 32'h4);
      expect_cc(0, 8'h94, 5'h1f);
      send(0, 8'h94);
      repeat (10) @(posedge I_CLK);
      rd(6'h02, st | 32'h2);
      $display("test extended done");
      check("queue", 32'(expq.size()), 32'h0);
      finish_test();
   end
endmodule : rcd_router_ctrl_tb
`default_nettype wire
